// File: core/lp_mode_map.svh
`ifndef LP_MODE_MAP_SVH
`define LP_MODE_MAP_SVH
// Operation
// (RQ1) After any reset the device runs until software picks a low-power mode.
// (RQ2) Sleep halts only the CPU; any interrupt or event resumes it.
// (RQ3) Both Stop modes keep RAM and register contents.
// (RQ4) Stop stops core clocks, PLL and fast oscillators; slow oscillator keeps running.
// (RQ5) Clock, tamper, watchdog and radio sleep counter may stay active in Stop.
// (RQ6) Stop 0 keeps main regulator on; Stop 1 uses the low-power regulator.
// (RQ7) Leaving either Stop mode selects the internal 16 MHz oscillator.
// (RQ8) Standby removes core power, PLL and fast oscillators; slow oscillator runs.
// (RQ9) Brownout monitor always on in Standby; ultra-low-power option for Stop 1/Standby.
// (RQ10) In Standby each I/O holds pull-up, pull-down or floating configuration.
// (RQ11) Standby loses RAM except optionally retained first and second banks.
// (RQ12) Radio may be kept powered in Standby as a retention variant.
// (RQ13) Standby exits on reset pin, watchdog, wake pin edge, clock event, tamper.
// (RQ14) Radio sleep counter wakes Standby only in the radio-retention variant.
// (RQ15) After Standby wake-up the system clock is the 16 MHz oscillator.
// (RQ16) Listed peripherals run autonomously in Stop 0; radio only in range 1.
// (RQ17) In Stop 1 autonomous peripherals may request a move to Stop 0.
// (RQ18) Kernel clock turns on when requested and off when nobody requests it.
// (RQ19) System-clock request enters Stop 0 and distributes the 16 MHz oscillator.
// (RQ20) With no bus clock request and Stop 1 selected, return to Stop 1.
// (RQ21) Peripheral triggers start work; peripheral interrupts wake the system from Stop.
// (RQ22) DMA stays fully functional in Stop 0 without waking the CPU.
// (RQ23) Hardware triggers start memory DMA and gate peripheral DMA.
// (RQ24) Software programs mode and retention before the CPU requests low power.
`define ADDR_MODE_CTRL    12'h000
`define ADDR_RETENTION    12'h004
`define ADDR_WAKE_CFG     12'h008
`define ADDR_STATUS       12'h00C
`define ADDR_IO_PULL_UP   12'h010
`define ADDR_IO_PULL_DOWN 12'h014
// Mode control: [2:0] selected mode, [3] brownout ultra-low-power, [4] voltage range 2.
`define MODE_SEL_LSB      0
`define MODE_SEL_MSB      2
`define BOR_ULP_BIT       3
`define RANGE2_BIT        4
// Retention: [0] first bank, [1] second bank, [2] radio.
`define RET_RAM1_BIT      0
`define RET_RAM2_BIT      1
`define RET_RADIO_BIT     2
// Wake config: [0] wake pin falling edge when set.
`define WAKE_FALL_BIT     0
`define STANDBY_SOURCES   6
`define AUTO_PERIPHS      8
`define RESET_WORD        32'h0000_0000
`endif

// File: core/lp_mode_pkg.sv
package lp_mode_pkg;
   typedef enum logic [2:0] {
      sel_sleep          = 3'd0,
      sel_stop0          = 3'd1,
      sel_stop1          = 3'd2,
      sel_standby        = 3'd3,
      sel_standby_ret    = 3'd4
   } sel_mode_type;

   // Gray codes along the order run, sleep, stop 0, stop 1, standby.
   typedef enum logic [2:0] {
      st_run     = 3'b000,
      st_sleep   = 3'b001,
      st_stop0   = 3'b011,
      st_stop1   = 3'b010,
      st_standby = 3'b110
   } power_state_type;

   typedef struct packed {
      logic main_regulator_on;
      logic low_power_regulator_on;
      logic core_supply_domain_on;
      logic cpu_clock_on;
      logic core_clocks_on;
      logic pll_on;
      logic internal_16mhz_oscillator_on;
      logic external_32mhz_crystal_osc_on;
      logic low_speed_osc_on;
      logic sys_clk_is_16mhz;
   } power_ctrl_type;

   typedef struct packed {
      logic external_reset_pin;
      logic independent_watchdog;
      logic wakeup_pin;
      logic rtc_event;
      logic tamper_unit;
      logic radio_sleep_counter;
   } standby_wake_type;
endpackage

// File: core/low_power_mode_controller.sv
`timescale 1ns/1ps
`include "lp_mode_map.svh"
module low_power_mode_controller #(
   parameter int NUM_AUTO = `AUTO_PERIPHS
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [11:0]                 paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        cpu_sleep_req,
   input  wire logic                        any_irq_event,
   input  wire logic [NUM_AUTO-1:0]         kernel_clk_req,
   input  wire logic [NUM_AUTO-1:0]         bus_clk_req,
   input  wire logic [NUM_AUTO-1:0]         periph_wake_irq,
   input  wire logic                        hw_trigger,
   input  wire logic                        dma_mem_to_mem,
   input  wire lp_mode_pkg::standby_wake_type standby_wake_in,
   input  wire logic                        wakeup_pin,
   output lp_mode_pkg::power_ctrl_type      power_ctrl,
   output lp_mode_pkg::power_state_type     power_state,
   output logic                             kernel_clk_en,
   output logic                             bus_clk_en,
   output logic                             dma_enable,
   output logic                             dma_start,
   output logic                             radio_autonomous,
   output logic                             first_ram_bank_on,
   output logic                             second_ram_bank_on,
   output logic                             radio_power_on,
   output logic                             ram_reg_retained,
   output logic                             brownout_reset_monitor_on,
   output logic                             brownout_ulp,
   output logic                             always_on_units_en,
   output logic                             io_hold,
   output logic [15:0]                      io_pull_up,
   output logic [15:0]                      io_pull_down,
   output logic                             wake_from_standby
);
   import lp_mode_pkg::*;

   initial begin
      if (NUM_AUTO < 1 || NUM_AUTO > 32) begin
         $error("NUM_AUTO must lie between 1 and 32.");
      end
   end

   logic [4:0]      mode_ctrl;
   logic [2:0]      retention;
   logic            wake_fall;
   logic [15:0]     pull_up_cfg;
   logic [15:0]     pull_down_cfg;
   power_state_type state;
   power_state_type next_state;
   logic            wakeup_pin_q;
   logic            wake_pin_edge;
   logic            standby_wake;
   logic            any_bus_req;
   logic            any_periph_wake;
   sel_mode_type    sel_mode;

   wire apb_write = psel && penable && pwrite;
   wire apb_read  = psel && !penable && !pwrite;
   assign sel_mode = sel_mode_type'(mode_ctrl[`MODE_SEL_MSB:`MODE_SEL_LSB]);
   assign pready   = 1'b1;

   always_comb begin
      pslverr = 1'b0;
      if (psel && penable) begin
         unique case (paddr)
            `ADDR_MODE_CTRL, `ADDR_RETENTION, `ADDR_WAKE_CFG, `ADDR_STATUS,
            `ADDR_IO_PULL_UP, `ADDR_IO_PULL_DOWN: pslverr = 1'b0;
            default: pslverr = 1'b1;
         endcase
      end
   end

   // (RQ24) Software mode setup.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ctrl     <= 5'h00;
         retention     <= 3'h0;
         wake_fall     <= 1'b0;
         pull_up_cfg   <= 16'h0000;
         pull_down_cfg <= 16'h0000;
      end else if (apb_write) begin
         unique case (paddr)
            `ADDR_MODE_CTRL:    mode_ctrl     <= pwdata[4:0];
            `ADDR_RETENTION:    retention     <= pwdata[2:0];
            `ADDR_WAKE_CFG:     wake_fall     <= pwdata[`WAKE_FALL_BIT];
            `ADDR_IO_PULL_UP:   pull_up_cfg   <= pwdata[15:0];
            `ADDR_IO_PULL_DOWN: pull_down_cfg <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Read data is registered in the setup cycle so it is valid in the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `RESET_WORD;
      end else if (apb_read) begin
         unique case (paddr)
            `ADDR_MODE_CTRL:    prdata <= {27'h0, mode_ctrl};
            `ADDR_RETENTION:    prdata <= {29'h0, retention};
            `ADDR_WAKE_CFG:     prdata <= {31'h0, wake_fall};
            `ADDR_STATUS:       prdata <= {26'h0, bus_clk_en, kernel_clk_en, 1'b0, state};
            `ADDR_IO_PULL_UP:   prdata <= {16'h0, pull_up_cfg};
            `ADDR_IO_PULL_DOWN: prdata <= {16'h0, pull_down_cfg};
            default:            prdata <= `RESET_WORD;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wakeup_pin_q <= 1'b0;
      end else begin
         wakeup_pin_q <= wakeup_pin;
      end
   end

   assign wake_pin_edge = wake_fall ? (wakeup_pin_q && !wakeup_pin)
                                    : (!wakeup_pin_q && wakeup_pin);
   assign any_bus_req     = |bus_clk_req;
   assign any_periph_wake = |periph_wake_irq;

   // (RQ13) Standby exit sources.
   always_comb begin
      standby_wake = standby_wake_in.external_reset_pin || standby_wake_in.independent_watchdog
                  || wake_pin_edge || standby_wake_in.rtc_event || standby_wake_in.tamper_unit;
      // (RQ14) Radio counter wake.
      if (retention[`RET_RADIO_BIT] && standby_wake_in.radio_sleep_counter) begin
         standby_wake = 1'b1;
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         st_run: begin
            if (cpu_sleep_req) begin
               unique case (sel_mode)
                  sel_sleep:   next_state = st_sleep;
                  sel_stop0:   next_state = st_stop0;
                  sel_stop1:   next_state = any_bus_req ? st_stop0 : st_stop1;
                  default:     next_state = st_standby;
               endcase
            end
         end
         // (RQ2) Sleep resume.
         st_sleep:   if (any_irq_event) next_state = st_run;
         st_stop0: begin
            // (RQ21) Peripheral wake.
            if (any_periph_wake || any_irq_event) begin
               next_state = st_run;
            // (RQ20) Return to Stop 1.
            end else if (!any_bus_req && sel_mode == sel_stop1) begin
               next_state = st_stop1;
            end
         end
         st_stop1: begin
            if (any_periph_wake || any_irq_event) begin
               next_state = st_run;
            // (RQ17) Move to Stop 0.
            end else if (any_bus_req) begin
               next_state = st_stop0;
            end
         end
         st_standby: if (standby_wake) next_state = st_run;
         default:    next_state = st_run;
      endcase
   end

   // (RQ1) Reset to run.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= st_run;
      end else begin
         state <= next_state;
      end
   end

   wire in_stop    = (state == st_stop0) || (state == st_stop1);
   wire in_standby = (state == st_standby);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_ctrl <= '{main_regulator_on: 1'b1, low_power_regulator_on: 1'b0,
                         core_supply_domain_on: 1'b1, cpu_clock_on: 1'b1,
                         core_clocks_on: 1'b1, pll_on: 1'b0,
                         internal_16mhz_oscillator_on: 1'b1,
                         external_32mhz_crystal_osc_on: 1'b0,
                         low_speed_osc_on: 1'b1, sys_clk_is_16mhz: 1'b1};
      end else begin
         // (RQ6) Regulator choice.
         power_ctrl.main_regulator_on      <= !(next_state == st_stop1) && !(next_state == st_standby);
         power_ctrl.low_power_regulator_on <= (next_state == st_stop1) || (next_state == st_standby);
         // (RQ8) Standby power off.
         power_ctrl.core_supply_domain_on  <= next_state != st_standby;
         // (RQ2) CPU clock gate.
         power_ctrl.cpu_clock_on           <= next_state == st_run;
         // (RQ4) Stop clock gating.
         power_ctrl.core_clocks_on <= (next_state == st_run) || (next_state == st_sleep)
                                   || ((next_state == st_stop0) && any_bus_req);
         power_ctrl.pll_on <= ((next_state == st_run) || (next_state == st_sleep))
                           && power_ctrl.pll_on;
         // (RQ19) Oscillator on request.
         power_ctrl.internal_16mhz_oscillator_on <= (next_state == st_run)
                           || (next_state == st_sleep) || ((next_state == st_stop0) && any_bus_req);
         power_ctrl.external_32mhz_crystal_osc_on <= 1'b0;
         power_ctrl.low_speed_osc_on <= 1'b1;
         // (RQ7) Wake clock select.
         if ((in_stop || in_standby) && next_state == st_run) begin
            power_ctrl.sys_clk_is_16mhz <= 1'b1;
         end
      end
   end

   // (RQ18) Kernel clock on demand.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kernel_clk_en <= 1'b0;
         bus_clk_en    <= 1'b0;
      end else begin
         kernel_clk_en <= |kernel_clk_req;
         bus_clk_en    <= any_bus_req && !in_standby;
      end
   end

   // (RQ22) DMA in Stop 0.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_enable       <= 1'b1;
         dma_start        <= 1'b0;
         radio_autonomous <= 1'b0;
      end else begin
         dma_enable <= (next_state == st_run) || (next_state == st_sleep)
                    || ((next_state == st_stop0) && any_bus_req);
         // (RQ23) Trigger start and gating.
         dma_start  <= hw_trigger && (dma_mem_to_mem || dma_enable);
         // (RQ16) Radio autonomy range.
         radio_autonomous <= (next_state == st_stop0) && !mode_ctrl[`RANGE2_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_ram_bank_on         <= 1'b1;
         second_ram_bank_on        <= 1'b1;
         radio_power_on            <= 1'b1;
         ram_reg_retained          <= 1'b1;
         brownout_reset_monitor_on <= 1'b1;
         brownout_ulp              <= 1'b0;
         always_on_units_en        <= 1'b1;
         io_hold                   <= 1'b0;
         io_pull_up                <= 16'h0000;
         io_pull_down              <= 16'h0000;
         wake_from_standby         <= 1'b0;
      end else begin
         // (RQ11) Bank retention.
         first_ram_bank_on  <= !(next_state == st_standby) || retention[`RET_RAM1_BIT];
         second_ram_bank_on <= !(next_state == st_standby) || retention[`RET_RAM2_BIT];
         // (RQ12) Radio retention.
         radio_power_on     <= !(next_state == st_standby) || retention[`RET_RADIO_BIT];
         // (RQ3) Stop keeps contents.
         ram_reg_retained   <= next_state != st_standby;
         // (RQ9) Brownout stays on.
         brownout_reset_monitor_on <= 1'b1;
         brownout_ulp <= mode_ctrl[`BOR_ULP_BIT]
                      && ((next_state == st_stop1) || (next_state == st_standby));
         // (RQ5) Always-on units.
         always_on_units_en <= 1'b1;
         // (RQ10) I/O pull hold.
         io_hold      <= next_state == st_standby;
         io_pull_up   <= (next_state == st_standby) ? pull_up_cfg : 16'h0000;
         io_pull_down <= (next_state == st_standby) ? pull_down_cfg : 16'h0000;
         // (RQ15) Standby wake clock.
         wake_from_standby <= in_standby && standby_wake;
      end
   end

   assign power_state = state;

   a_sleep_resume: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
      state == st_sleep && any_irq_event |=> state == st_run)
      else $error("Sleep did not resume.");
   a_stop_clocks: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
      state == st_stop1 |-> !power_ctrl.core_clocks_on && !power_ctrl.pll_on
                            && power_ctrl.low_speed_osc_on)
      else $error("Clocks running in Stop 1.");
   a_stop1_regulator: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
      state == st_stop1 |-> !power_ctrl.main_regulator_on && power_ctrl.low_power_regulator_on)
      else $error("Wrong regulator in Stop 1.");
   a_standby_power: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
      state == st_standby |-> !power_ctrl.core_supply_domain_on
                              && !power_ctrl.internal_16mhz_oscillator_on)
      else $error("Core powered in Standby.");
   a_radio_wake: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
      state == st_standby && !retention[`RET_RADIO_BIT] && standby_wake_in == 6'b000001
      && !wake_pin_edge |=> state == st_standby)
      else $error("Radio counter woke plain Standby.");
   a_stop0_move: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
      state == st_stop1 && any_bus_req && !any_periph_wake && !any_irq_event
      |=> state == st_stop0 ##1 power_ctrl.internal_16mhz_oscillator_on || state != st_stop0)
      else $error("No move to Stop 0.");
   a_stop1_return: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
      state == st_stop0 && !any_bus_req && sel_mode == sel_stop1
      && !any_periph_wake && !any_irq_event |=> state == st_stop1)
      else $error("No return to Stop 1.");
   a_kernel_clock: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
      (|kernel_clk_req) |=> kernel_clk_en)
      else $error("Kernel clock not granted.");
   a_io_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
      state == st_standby |-> io_hold && io_pull_up == pull_up_cfg)
      else $error("I/O state not held.");
endmodule

// File: dv/auto_periph_model.sv
`timescale 1ns/1ps
module auto_periph_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       go,
   input  wire logic [2:0] idx,
   input  wire logic [7:0] len,
   input  wire logic       wake,
   output logic [7:0]      kernel_clk_req,
   output logic [7:0]      bus_clk_req,
   output logic [7:0]      periph_wake_irq,
   output logic            hw_trigger,
   output logic            dma_mem_to_mem
);
   logic [2:0] phase;
   logic [7:0] cnt;
   logic [7:0] one_hot;
   assign one_hot = 8'h01 << idx;
   // The kernel clock is asked for well before and after the bus phase, as a peripheral does.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 3'h0;
         cnt <= 8'h00;
      end else if (phase == 3'h0) begin
         if (go) begin
            phase <= 3'h1;
            cnt <= 8'h06;
         end
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end else begin
         phase <= (phase == 3'h1) ? 3'h2 : (phase == 3'h2) ? 3'h3 :
                  (phase == 3'h3 && wake) ? 3'h4 : 3'h0;
         cnt <= (phase == 3'h1) ? len : 8'h03;
      end
   end
   assign hw_trigger      = phase == 3'h2;
   assign dma_mem_to_mem  = phase == 3'h2;
   assign kernel_clk_req  = (phase != 3'h0 && phase != 3'h4) ? one_hot : 8'h00;
   assign bus_clk_req     = (phase == 3'h2) ? one_hot : 8'h00;
   assign periph_wake_irq = (phase == 3'h4) ? one_hot : 8'h00;
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
`include "lp_mode_map.svh"
module tb_top;
   import lp_mode_pkg::*;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic             cpu_sleep_req, any_irq_event, wakeup_pin, go, wake, trig, m2m;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic [7:0]       kreq, breq, wirq, len;
   logic [2:0]       idx;
   standby_wake_type sw_in;
   power_ctrl_type   pc;
   power_state_type  ps;
   logic             kclk, bclk, dma_en, dma_start, radio_auto, ram1, ram2, radio_on;
   logic             retained, bor_on, bor_ulp, aon, io_hold, dma_seen, wfs;
   logic [15:0]      pu, pd;
   int               mismatches, checks_done, wakes;
   low_power_mode_controller dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_sleep_req(cpu_sleep_req),
      .any_irq_event(any_irq_event), .kernel_clk_req(kreq), .bus_clk_req(breq),
      .periph_wake_irq(wirq), .hw_trigger(trig), .dma_mem_to_mem(m2m),
      .standby_wake_in(sw_in), .wakeup_pin(wakeup_pin), .power_ctrl(pc), .power_state(ps),
      .kernel_clk_en(kclk), .bus_clk_en(bclk), .dma_enable(dma_en), .dma_start(dma_start),
      .radio_autonomous(radio_auto), .first_ram_bank_on(ram1), .second_ram_bank_on(ram2),
      .radio_power_on(radio_on), .ram_reg_retained(retained),
      .brownout_reset_monitor_on(bor_on), .brownout_ulp(bor_ulp), .always_on_units_en(aon),
      .io_hold(io_hold), .io_pull_up(pu), .io_pull_down(pd), .wake_from_standby(wfs));
   auto_periph_model far_side (.pclk(pclk), .presetn(presetn), .go(go), .idx(idx),
      .len(len), .wake(wake), .kernel_clk_req(kreq), .bus_clk_req(breq),
      .periph_wake_irq(wirq), .hw_trigger(trig), .dma_mem_to_mem(m2m));
   always #2 pclk = ~pclk;
   always @(posedge pclk) begin
      if (dma_start === 1'b1)
         dma_seen <= 1'b1;
      if (wfs === 1'b1)
         wakes <= wakes + 1;
   end
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No bound on this wait; pready ends it, and the slave decides how long it takes.
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Polls the state under a bound, then lets the registered outputs follow.
   task wait_st(input power_state_type s);
      int i;
      for (i = 0; i < 60; i++) begin
         if (ps === s)
            break;
         @(posedge pclk);
      end
      repeat (2) @(posedge pclk);
   endtask
   task enter(input power_state_type s);
      cpu_sleep_req <= 1'b1;
      wait_st(s);
      cpu_sleep_req <= 1'b0;
      chk(ps, s); // programmed mode applied.
   endtask
   task irq_wake;
      any_irq_event <= 1'b1;
      wait_st(st_run);
      any_irq_event <= 1'b0;
      chk(ps, st_run); // any event resumes.
   endtask
   task t_regs;
      chk(ps, st_run); // run after reset.
      apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0000); // run, no clock requests.
      apb(1'b1, `ADDR_IO_PULL_UP, 32'hFFFF_FFFF);
      apb(1'b0, `ADDR_IO_PULL_UP, 32'h0000_0000);
      chk(rd, 32'h0000_FFFF); // pull-ups read back.
      apb(1'b0, 12'h018, 32'h0000_0000);
      chk(err, 32'h0000_0001); // unmapped offset refused.
      chk(rd, 32'h0000_0000); // unmapped offset reads zero.
      $display("test regs done");
   endtask
   task t_sleep;
      apb(1'b1, `ADDR_MODE_CTRL, 32'h0000_0000);
      enter(st_sleep);
      chk(pc.cpu_clock_on, 1'b0); // cpu halted.
      chk(pc.core_clocks_on, 1'b1); // peripherals run.
      irq_wake;
      $display("test sleep done");
   endtask
   task t_stop0;
      apb(1'b1, `ADDR_MODE_CTRL, 32'h0000_0011);
      enter(st_stop0);
      chk(pc.core_clocks_on, 1'b0); // core clocks stop.
      chk(pc.pll_on, 1'b0); // pll off.
      chk(pc.internal_16mhz_oscillator_on, 1'b0); // fast osc off.
      chk(pc.external_32mhz_crystal_osc_on, 1'b0); // crystal off.
      chk(pc.low_speed_osc_on, 1'b1); // slow osc runs.
      chk(pc.main_regulator_on, 1'b1); // main regulator on.
      chk(retained, 1'b1); // contents kept.
      chk(aon, 1'b1); // always-on units.
      chk(radio_auto, 1'b0); // radio range 1 only.
      irq_wake;
      chk(pc.sys_clk_is_16mhz, 1'b1); // exit clock.
      $display("test stop0 done");
   endtask
   task t_bam;
      apb(1'b1, `ADDR_MODE_CTRL, 32'h0000_000A);
      enter(st_stop1);
      chk(pc.main_regulator_on, 1'b0); // low-power regulator only.
      chk(pc.low_power_regulator_on, 1'b1); // low-power regulator on.
      chk(bor_ulp, 1'b1); // ultra-low-power in stop 1.
      chk(retained, 1'b1); // contents kept.
      idx <= 3'h3;
      len <= 8'h10;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(kclk, 1'b1); // kernel clock on request.
      chk(ps, st_stop1); // kernel request alone stays.
      wait_st(st_stop0);
      chk(ps, st_stop0); // move to stop 0.
      chk(pc.internal_16mhz_oscillator_on, 1'b1); // fast osc woken.
      chk(bclk, 1'b1); // bus clock given.
      chk(dma_en, 1'b1); // dma runs.
      chk(radio_auto, 1'b1); // range 1 radio.
      wait_st(st_stop1);
      chk(ps, st_stop1); // back to stop 1.
      repeat (8) @(posedge pclk);
      chk(kclk, 1'b0); // kernel clock off.
      chk(dma_seen, 1'b1); // trigger starts dma.
      wake <= 1'b1;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      wait_st(st_run);
      chk(ps, st_run); // peripheral interrupt wakes.
      wake <= 1'b0;
      $display("test bam done");
   endtask
   task t_standby;
      logic [5:0] srcs [4];
      int         i;
      srcs = '{6'h20, 6'h10, 6'h04, 6'h02};
      apb(1'b1, `ADDR_RETENTION, 32'h0000_0001);
      apb(1'b1, `ADDR_IO_PULL_UP, 32'h0000_00A5);
      apb(1'b1, `ADDR_IO_PULL_DOWN, 32'h0000_5A00);
      apb(1'b1, `ADDR_WAKE_CFG, 32'h0000_0000);
      apb(1'b1, `ADDR_MODE_CTRL, 32'h0000_000B);
      enter(st_standby);
      chk(pc.core_supply_domain_on, 1'b0); // core power off.
      chk(pc.pll_on, 1'b0); // pll off.
      chk(pc.internal_16mhz_oscillator_on, 1'b0); // fast osc off.
      chk(pc.external_32mhz_crystal_osc_on, 1'b0); // crystal off.
      chk(pc.low_speed_osc_on, 1'b1); // slow osc runs.
      chk(bor_on, 1'b1); // brownout stays on.
      chk(bor_ulp, 1'b1); // ultra-low-power in standby.
      chk(io_hold, 1'b1); // pins held.
      chk(pu, 16'h00A5); // pull-ups applied.
      chk(pd, 16'h5A00); // pull-downs applied.
      chk(ram1, 1'b1); // first bank kept.
      chk(ram2, 1'b0); // second bank dropped.
      chk(retained, 1'b0); // contents lost.
      chk(radio_on, 1'b0); // radio off.
      sw_in <= standby_wake_type'(6'h01);
      repeat (6) @(posedge pclk);
      chk(ps, st_standby); // counter ignored.
      sw_in <= standby_wake_type'(6'h00);
      wakeup_pin <= 1'b1;
      wait_st(st_run);
      chk(ps, st_run); // rising wake pin.
      chk(pc.sys_clk_is_16mhz, 1'b1); // wake clock.
      for (i = 0; i < 4; i++) begin
         enter(st_standby);
         sw_in <= standby_wake_type'(srcs[i]);
         wait_st(st_run);
         chk(ps, st_run); // each source wakes.
         sw_in <= standby_wake_type'(6'h00);
      end
      chk(wakes, 32'd5); // one wake pulse per exit.
      $display("test standby done");
   endtask
   task t_ret;
      apb(1'b1, `ADDR_RETENTION, 32'h0000_0007);
      apb(1'b1, `ADDR_WAKE_CFG, 32'h0000_0001);
      apb(1'b1, `ADDR_MODE_CTRL, 32'h0000_0004);
      enter(st_standby);
      chk(radio_on, 1'b1); // radio retained.
      chk(ram2, 1'b1); // second bank kept.
      sw_in <= standby_wake_type'(6'h01);
      wait_st(st_run);
      chk(ps, st_run); // counter wakes.
      sw_in <= standby_wake_type'(6'h00);
      enter(st_standby);
      wakeup_pin <= 1'b0;
      wait_st(st_run);
      chk(ps, st_run); // falling wake pin.
      $display("test retention done");
   endtask
   initial begin
      #80000;
      mismatches++;
      close_out;
   end
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {cpu_sleep_req, any_irq_event, wakeup_pin, go, wake, idx, len} = '0;
      sw_in = standby_wake_type'(6'h00);
      dma_seen = 1'b0;
      wakes = 0;
      mismatches = 0;
      checks_done = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_sleep;
      t_stop0;
      t_bam;
      t_standby;
      t_ret;
      close_out;
   end
endmodule
